/* File: verilog/motion_cmd_host.sv */
// Host controller that issues commands to the motion device bus
//
// Decided for this implementation: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module motion_cmd_host
	import motion_cmd_pkg::*;
(
	input  wire logic        MCLK_IN,
	input  wire logic        RST_B_IN,
	input  wire logic        CE_IN,
	input  wire logic [3:0]  AVS_ADDRESS_IN,
	input  wire logic        AVS_READ_IN,
	input  wire logic        AVS_WRITE_IN,
	input  wire logic [31:0] AVS_WRITEDATA_IN,
	output logic      [31:0] AVS_READDATA_OUT,
	output logic             AVS_WAITREQUEST_OUT,
	output logic      [2:0]  DEV_ADDR_OUT,
	output logic             DEV_CS_B_OUT,
	output logic             DEV_WR_B_OUT,
	output logic             DEV_RD_B_OUT,
	input  wire logic [15:0] DEV_DATA_IN,
	output logic      [15:0] DEV_DATA_OUT,
	output logic             DEV_DATA_OE_OUT
);
	////////////////////////////////////////////////////////////////////////
	// Decode functions
	// listed codes
	function automatic logic code_legal(input logic [7:0] c);
		code_legal = (c <= CMD_RD_LAST) || (c >= CMD_DRV_FIRST && c <= CMD_DRV_LAST)
			|| (c >= CMD_EXT_FIRST && c <= CMD_EXT_LAST);
	endfunction

	// lengths: 0 none, 1 two, 2 four bytes
	function automatic logic [1:0] data_len(input logic [7:0] c);
		case (c)
			8'h00, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h60, 8'h64:
				data_len = 2'd2;
			8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h0D, 8'h0E, 8'h61:
				data_len = 2'd1;
			default:
				data_len = 2'd0;
		endcase
	endfunction

	function automatic logic range_ok(input logic [7:0] c, input logic [31:0] d);
		if (c == CMD_RANGE)
			range_ok = d >= RANGE_MIN && d <= RANGE_MAX;
		else if ((c >= CMD_ACCEL && c <= CMD_SPEED) || c == CMD_HOME_SPEED)
			range_ok = d >= SPEED_MIN && d <= SPEED_MAX;
		else
			range_ok = 1'b1;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Reset release and pin synchroniser
	logic [1:0]  rst_sync;
	logic        rst_b;
	logic [15:0] data_meta;
	logic [15:0] data_sync;

	always_ff @(posedge MCLK_IN or negedge RST_B_IN)
	begin
		if (!RST_B_IN)
			rst_sync <= 2'b00;
		else
			rst_sync <= {rst_sync[0], 1'b1};
	end
	assign rst_b = rst_sync[1];

	always_ff @(posedge MCLK_IN or negedge rst_b)
	begin
		if (!rst_b)
		begin
			data_meta <= 16'h0000;
			data_sync <= 16'h0000;
		end
		else if (CE_IN)
		begin
			data_meta <= DEV_DATA_IN;
			data_sync <= data_meta;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Avalon slave handshake
	state_e      state;
	logic [4:0]  cnt;
	logic        ack;
	logic        req;
	logic        stall;
	logic        wr_en;
	logic        go;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic [7:0]  code;
	logic [3:0]  axes;
	logic        bad_code;
	logic        bad_range;
	logic        not_ready;
	logic        range_set;
	logic        speed_set;
	logic [7:0]  new_code;
	logic        new_legal;
	logic        new_fit;
	logic        new_drive;
	logic        accepted;
	logic [31:0] status;

	assign req = AVS_READ_IN | AVS_WRITE_IN;
	assign stall = AVS_WRITE_IN && AVS_ADDRESS_IN == REG_CTRL && state != S_IDLE;
	assign AVS_WAITREQUEST_OUT = req & ~ack;
	assign wr_en = AVS_WRITE_IN & ack;
	assign go = wr_en && AVS_ADDRESS_IN == REG_CTRL;
	assign new_code = AVS_WRITEDATA_IN[CTRL_CODE_LSB +: 8];
	assign new_legal = code_legal(new_code);
	assign new_fit = range_ok(new_code, wdata);
	assign new_drive = new_code >= CMD_DRV_FIRST && new_code <= CMD_DRV_CONT_M;
	assign accepted = go && new_legal && new_fit && !(new_drive && !(range_set && speed_set));
	assign status = {26'h0, speed_set, range_set, not_ready, bad_range, bad_code, state != S_IDLE};

	always_ff @(posedge MCLK_IN or negedge rst_b)
	begin
		if (!rst_b)
			ack <= 1'b0;
		else if (CE_IN)
			ack <= req & ~ack & ~stall;
	end

	always_ff @(posedge MCLK_IN or negedge rst_b)
	begin
		if (!rst_b)
			AVS_READDATA_OUT <= WORD_RESET;
		else if (CE_IN && AVS_READ_IN && !ack)
		begin
			case (AVS_ADDRESS_IN)
				REG_WDATA:  AVS_READDATA_OUT <= wdata;
				REG_RDATA:  AVS_READDATA_OUT <= rdata;
				REG_STATUS: AVS_READDATA_OUT <= status;
				default:    AVS_READDATA_OUT <= WORD_RESET;
			endcase
		end
	end

	always_ff @(posedge MCLK_IN or negedge rst_b)
	begin
		if (!rst_b)
			wdata <= WORD_RESET;
		else if (CE_IN && wr_en && AVS_ADDRESS_IN == REG_WDATA)
			wdata <= AVS_WRITEDATA_IN;
	end

	////////////////////////////////////////////////////////////////////////
	// Error flags, set wins over write-one clear
	always_ff @(posedge MCLK_IN or negedge rst_b)
	begin
		if (!rst_b)
		begin
			bad_code  <= 1'b0;
			bad_range <= 1'b0;
			not_ready <= 1'b0;
		end
		else if (CE_IN)
		begin
			if (wr_en && AVS_ADDRESS_IN == REG_STATUS)
			begin
				bad_code  <= bad_code & ~AVS_WRITEDATA_IN[ST_BAD_CODE];
				bad_range <= bad_range & ~AVS_WRITEDATA_IN[ST_BAD_RANGE];
				not_ready <= not_ready & ~AVS_WRITEDATA_IN[ST_NOT_READY];
			end
			if (go && !new_legal)
				bad_code <= 1'b1;
			if (go && new_legal && !new_fit)
				bad_range <= 1'b1;
			if (go && new_legal && new_fit && new_drive && !(range_set && speed_set))
				not_ready <= 1'b1;
		end
	end

	always_ff @(posedge MCLK_IN or negedge rst_b)
	begin
		if (!rst_b)
		begin
			range_set <= 1'b0;
			speed_set <= 1'b0;
		end
		else if (CE_IN && accepted)
		begin
			if (new_code == CMD_RANGE)
				range_set <= 1'b1;
			if (new_code == CMD_SPEED)
				speed_set <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Command sequencer
	always_ff @(posedge MCLK_IN or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state <= S_IDLE;
			cnt   <= 5'd0;
			code  <= 8'h00;
			axes  <= 4'h0;
			rdata <= WORD_RESET;
		end
		else if (CE_IN)
		begin
			case (state)
				S_IDLE:
				begin
					cnt <= 5'd0;
					if (accepted)
					begin
						code <= new_code;
						axes <= AVS_WRITEDATA_IN[CTRL_AXES_LSB +: 4];
						case (data_len(new_code))
							2'd2:    state <= S_WR_HI;
							2'd1:    state <= S_WR_LO;
							default: state <= S_WR_CMD;
						endcase
					end
				end
				S_WR_HI, S_WR_LO, S_WR_CMD, S_RD_LO, S_RD_HI:
				begin
					cnt <= cnt + 5'd1;
					if (cnt == ACCESS_CYC - 5'd1)
					begin
						cnt <= 5'd0;
						case (state)
							S_WR_HI:  state <= S_WR_LO;
							S_WR_LO:  state <= S_WR_CMD;
							S_WR_CMD: state <= S_GAP;
							S_RD_LO:
							begin
								rdata[15:0] <= data_sync;
								state <= S_RD_HI;
							end
							default:
							begin
								rdata[31:16] <= data_sync;
								state <= S_IDLE;
							end
						endcase
					end
				end
				S_GAP:
				begin
					cnt <= cnt + 5'd1;
					if (cnt == CMD_GAP_CYC - 5'd1)
					begin
						cnt <= 5'd0;
						if (code >= CMD_RD_FIRST && code <= CMD_RD_LAST)
							state <= S_RD_LO;
						else
							state <= S_IDLE;
					end
				end
				default:
					state <= S_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registered device pins
	always_ff @(posedge MCLK_IN or negedge rst_b)
	begin
		if (!rst_b)
		begin
			DEV_ADDR_OUT    <= DEV_ADDR_CMD;
			DEV_CS_B_OUT    <= 1'b1;
			DEV_WR_B_OUT    <= 1'b1;
			DEV_RD_B_OUT    <= 1'b1;
			DEV_DATA_OUT    <= 16'h0000;
			DEV_DATA_OE_OUT <= 1'b0;
		end
		else if (CE_IN)
		begin
			DEV_CS_B_OUT    <= state == S_IDLE || state == S_GAP;
			DEV_WR_B_OUT    <= !(state >= S_WR_HI && state <= S_WR_CMD && cnt != 5'd0);
			DEV_RD_B_OUT    <= !((state == S_RD_LO || state == S_RD_HI) && cnt != 5'd0);
			DEV_DATA_OE_OUT <= state >= S_WR_HI && state <= S_WR_CMD;
			case (state)
				S_WR_HI, S_RD_HI: DEV_ADDR_OUT <= DEV_ADDR_HI;
				S_WR_LO, S_RD_LO: DEV_ADDR_OUT <= DEV_ADDR_LO;
				default:          DEV_ADDR_OUT <= DEV_ADDR_CMD;
			endcase
			case (state)
				S_WR_HI:  DEV_DATA_OUT <= wdata[31:16];
				S_WR_LO:  DEV_DATA_OUT <= wdata[15:0];
				S_WR_CMD: DEV_DATA_OUT <= {4'h0, axes, code};
				default:  DEV_DATA_OUT <= 16'h0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	logic [4:0] gap_len;

	always_ff @(posedge MCLK_IN or negedge rst_b)
	begin
		if (!rst_b)
			gap_len <= 5'd0;
		else if (CE_IN)
			gap_len <= (state == S_GAP) ? gap_len + 5'd1 : 5'd0;
	end

	default clocking cb @(posedge MCLK_IN);
	endclocking
	default disable iff (!rst_b || !CE_IN);

	strobe_excl_a: assert property (!(!DEV_WR_B_OUT && !DEV_RD_B_OUT))
		else $error("read and write strobes both active");
	cmd_gap_a: assert property ($fell(state == S_GAP) |-> gap_len == CMD_GAP_CYC)
		else $error("command gap length wrong");
	bad_code_a: assert property (go && !new_legal |=> state == S_IDLE && bad_code)
		else $error("unlisted code not refused");
	bad_range_a: assert property (go && new_legal && !new_fit |=> state == S_IDLE && bad_range)
		else $error("out of range value not refused");
	drive_ready_a: assert property (go && new_drive && !(range_set && speed_set) |=> state == S_IDLE)
		else $error("driving issued before parameters");
	word_order_a: assert property ($rose(state == S_WR_CMD) |-> $past(state) inside {S_WR_LO, S_IDLE})
		else $error("command written before data words");
	cmd_pins_a: assert property (state == S_WR_CMD && cnt == 5'd1 |=>
		DEV_ADDR_OUT == DEV_ADDR_CMD && !DEV_WR_B_OUT && DEV_DATA_OE_OUT && DEV_DATA_OUT == {4'h0, axes, code})
		else $error("command register write wrong");
	read_high_a: assert property ($fell(state == S_RD_HI) |-> rdata[31:16] == $past(data_sync))
		else $error("high read word not captured");
	hi_then_lo_a: assert property ($fell(state == S_WR_HI) |-> state == S_WR_LO)
		else $error("low word skipped after high word");

	read_cmd_c: cover property ($fell(state == S_RD_HI));
	four_byte_c: cover property ($fell(state == S_WR_HI));
	refused_c: cover property (go && !accepted);
	stall_c: cover property (stall ##1 stall);
endmodule
`default_nettype wire

/* File: verilog/motion_cmd_pkg.sv */
// Constants, field layouts and types of the motion command host controller
// Functional notes
// - Code 06 pulse count or finish point, four bytes.
// - Code 07 manual decel point, unsigned four bytes.
// - Codes 09 and 0A preset logical and real position, signed four bytes.
// - Codes 0B and 0C load upper and lower compare, signed four bytes.
// - Code 61 home detection speed, two bytes, 1 to 8000.
// - Codes 64 and 60 load mode bit fields, four bytes.
// - Host always writes every data word of the parameter length.
// - Host never issues a code outside the listed set.
// - Four bytes: high word then low word; two bytes: low word only.
// - Axis bits with code written to command_register execute the command.
// - No further command register access within 250 ns of a command.
// - Range and drive speed must be loaded before any driving command; the host checks this for codes 20 to 23 only, not 24 to 27.
// - Code 00 range, four bytes, 16000 to 8000000.
// - Code 05 drive speed, two bytes, 1 to 8000.
package motion_cmd_pkg;
	// Software register byte offsets
	localparam logic [3:0] REG_CTRL   = 4'h0;
	localparam logic [3:0] REG_WDATA  = 4'h4;
	localparam logic [3:0] REG_RDATA  = 4'h8;
	localparam logic [3:0] REG_STATUS = 4'hC;
	// Control field positions
	localparam int CTRL_CODE_LSB = 0;
	localparam int CTRL_AXES_LSB = 8;
	// Status bit positions
	localparam int ST_BUSY      = 0;
	localparam int ST_BAD_CODE  = 1;
	localparam int ST_BAD_RANGE = 2;
	localparam int ST_NOT_READY = 3;
	localparam int ST_RANGE_SET = 4;
	localparam int ST_SPEED_SET = 5;
	// Device word addresses
	localparam logic [2:0] DEV_ADDR_CMD = 3'h0;
	localparam logic [2:0] DEV_ADDR_LO  = 3'h6;
	localparam logic [2:0] DEV_ADDR_HI  = 3'h7;
	// Command codes used by the checks
	localparam logic [7:0] CMD_RANGE      = 8'h00;
	localparam logic [7:0] CMD_ACCEL      = 8'h02;
	localparam logic [7:0] CMD_SPEED      = 8'h05;
	localparam logic [7:0] CMD_AXIS_NOP   = 8'h0F;
	localparam logic [7:0] CMD_RD_FIRST   = 8'h10;
	localparam logic [7:0] CMD_RD_LAST    = 8'h14;
	localparam logic [7:0] CMD_DRV_FIRST  = 8'h20;
	localparam logic [7:0] CMD_DRV_CONT_M = 8'h23;
	localparam logic [7:0] CMD_DRV_LAST   = 8'h27;
	localparam logic [7:0] CMD_EXT_FIRST  = 8'h60;
	localparam logic [7:0] CMD_HOME_SPEED = 8'h61;
	localparam logic [7:0] CMD_SYNC_MODE  = 8'h64;
	localparam logic [7:0] CMD_EXT_LAST   = 8'h65;
	// Parameter limits
	localparam logic [31:0] SPEED_MIN = 32'h0000_0001;
	localparam logic [31:0] SPEED_MAX = 32'd8000;
	localparam logic [31:0] RANGE_MIN = 32'd16000;
	localparam logic [31:0] RANGE_MAX = 32'd8000000;
	// Reset values
	localparam logic [31:0] WORD_RESET = 32'h0000_0000;
	// Timing
	localparam int CLK_MHZ    = 50;
	localparam int ACCESS_NS  = 160;
	localparam int CMD_GAP_NS = 250;
	localparam logic [4:0] ACCESS_CYC  = 5'((ACCESS_NS * CLK_MHZ + 999) / 1000);
	localparam logic [4:0] CMD_GAP_CYC = 5'((CMD_GAP_NS * CLK_MHZ + 999) / 1000);

	typedef enum logic [2:0] {
		S_IDLE   = 3'b000,
		S_WR_HI  = 3'b001,
		S_WR_LO  = 3'b010,
		S_WR_CMD = 3'b011,
		S_GAP    = 3'b100,
		S_RD_LO  = 3'b101,
		S_RD_HI  = 3'b110
	} state_e;
endpackage

/* File: test/motion_dev_model.sv */
// Behavioural model of the motion device on its word bus
`timescale 1ns/1ps
`default_nettype none
module motion_dev_model
#(
	parameter int          LAG = 2,
	parameter logic [31:0] SB  = 32'h8765_4321
)
(
	input  wire logic        clk_in,
	input  wire logic [2:0]  addr_in,
	input  wire logic        cs_b_in,
	input  wire logic        wr_b_in,
	input  wire logic        rd_b_in,
	input  wire logic [15:0] data_in,
	output logic      [15:0] data_out
);
	logic [31:0] pmem [4][256];
	logic [31:0] rv;
	logic [15:0] wlo, whi, ld;
	logic [2:0]  la;
	logic [1:0]  sel = 2'h0;
	logic [7:0]  last_code;
	logic        act = 1'b0;
	logic        cs_q = 1'b1;
	int          nexec = 0, nwords = 0, words, gap = 1000, gap_bad = 0, rcnt = 0;
	initial data_out = 16'h0;
////////////////////////////////////////
	always @(posedge clk_in)
	begin
		gap++;
		rcnt = rd_b_in ? 0 : rcnt + 1;
		if (!cs_b_in && cs_q && gap < 13) gap_bad++;
		cs_q = cs_b_in;
		if (!cs_b_in && !wr_b_in)
		begin
			la = addr_in;
			ld = data_in;
			act = 1'b1;
		end
		else if (act)
		begin
			act = 1'b0;
			if (la == 3'h6) wlo = ld;
			if (la == 3'h7) whi = ld;
			if (la != 3'h0) nwords++;
			else
				run(ld[7:0], ld[11:8]);
		end
		if (!cs_b_in && !rd_b_in && rcnt > LAG) data_out <= addr_in[0] ? rv[31:16] : rv[15:0];
		else data_out <= ~data_out;
	end
////////////////////////////////////////
	// load every axis whose bit is set
	task automatic run(input logic [7:0] c, input logic [3:0] ax);
	begin
		for (int i = 3; i >= 0; i--)
		begin
			if (ax[i]) pmem[i][c] = nwords == 1 ? {16'h0, wlo} : {whi, wlo};
			if (ax[i]) sel = 2'(i);
		end
		case (c)
			8'h10: rv = pmem[sel][8'h09];
			8'h11: rv = pmem[sel][8'h0A];
			8'h12: rv = pmem[sel][8'h05];
			8'h13: rv = pmem[sel][8'h02];
			8'h14: rv = SB;
			default: ;
		endcase
		last_code = c;
		words = nwords;
		nwords = 0;
		nexec++;
		gap = 0;
	end
	endtask
endmodule
`default_nettype wire

/* File: test/motion_command_decoder_tb.sv */
// Self-checking bench of the motion command host controller
`timescale 1ns/1ps
`default_nettype none
module motion_command_decoder_tb
	import motion_cmd_pkg::*;
;
	logic        clk = 1'b0, rst_b = 1'b0, rd = 1'b0, wr = 1'b0;
	logic [3:0]  addr = 4'h0;
	logic [31:0] wdata = 32'h0, rdata, q, d;
	logic        wait_req, cs_b, wr_b, rd_b, oe;
	logic [2:0]  dev_addr;
	logic [15:0] hdata, mdata, bus;
	int          errors = 0, cmp_count = 0, n;
	assign bus = oe ? hdata : mdata;
	always #10 clk = ~clk;
	motion_cmd_host dut
	(
		.MCLK_IN(clk), .RST_B_IN(rst_b), .CE_IN(1'b1), .AVS_ADDRESS_IN(addr),
		.AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata),
		.AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(wait_req), .DEV_ADDR_OUT(dev_addr),
		.DEV_CS_B_OUT(cs_b), .DEV_WR_B_OUT(wr_b), .DEV_RD_B_OUT(rd_b), .DEV_DATA_IN(bus),
		.DEV_DATA_OUT(hdata), .DEV_DATA_OE_OUT(oe)
	);
	motion_dev_model #(.LAG(1)) dev
	(
		.clk_in(clk), .addr_in(dev_addr), .cs_b_in(cs_b), .wr_b_in(wr_b),
		.rd_b_in(rd_b), .data_in(bus), .data_out(mdata)
	);
////////////////////////////////////////
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
	begin
		cmp_count++;
		if (g !== e)
		begin
			errors++;
			$display("wrong value %s expected %h seen %h", s, e, g);
		end
	end
	endtask
	task automatic bus_op(input logic w, input logic [3:0] a, input logic [31:0] v);
	begin
		@(posedge clk);
		wr <= w;
		rd <= !w;
		addr <= a;
		wdata <= v;
		do
			@(posedge clk);
		while (wait_req !== 1'b0);
		q = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
	end
	endtask
	task automatic stat(input logic [5:0] e);
	begin
		bus_op(1'b0, REG_STATUS, 32'h0);
		chk("status", {26'h0, e}, q & 32'h3F);
	end
	endtask
	task automatic idle();
	begin
		for (int i = 0; i < 200; i++)
		begin
			bus_op(1'b0, REG_STATUS, 32'h0);
			if (q[ST_BUSY] === 1'b0) break;
		end
		chk("busy", 32'h0, {31'h0, q[ST_BUSY]});
	end
	endtask
	task automatic issue(input logic [7:0] c, input logic [3:0] ax, input logic [31:0] v);
	begin
		bus_op(1'b1, REG_WDATA, v);
		bus_op(1'b1, REG_CTRL, {20'h0, ax, c});
		idle();
	end
	endtask
	task automatic end_sim();
	begin
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	end
	endtask
////////////////////////////////////////
	task automatic t_refuse();
		logic [7:0] bad [3] = '{8'h15, 8'h30, 8'h66};
	begin
		stat(6'h00);
		bus_op(1'b0, 4'h2, 32'h0);
		chk("unmapped", 32'h0, q);
		n = dev.nexec;
		issue(CMD_DRV_FIRST, 4'h1, 32'h0);
		stat(6'h08);
		bus_op(1'b1, REG_STATUS, 32'hE);
		stat(6'h00);
		for (int i = 0; i < 3; i++)
		begin
			issue(bad[i], 4'h1, 32'h0);
			stat(6'h02);
			bus_op(1'b1, REG_STATUS, 32'hE);
		end
		chk("refused", n, dev.nexec);
		$display("refuse test done");
	end
	endtask
	task automatic t_limits();
		logic [7:0]  c [9] = '{8'h00, 8'h00, 8'h00, 8'h05, 8'h05, 8'h05, 8'h61, 8'h61, 8'h02};
		logic [31:0] v [9] = '{32'h3E7F, 32'h7A_1201, 32'h3E80, 32'h0, 32'h1F41, 32'h1F40, 32'h0, 32'h1F40, 32'h1};
		logic [5:0]  s [9] = '{6'h04, 6'h04, 6'h10, 6'h14, 6'h14, 6'h30, 6'h34, 6'h30, 6'h30};
	begin
		for (int i = 0; i < 9; i++)
		begin
			n = dev.nexec;
			issue(c[i], 4'hF, v[i]);
			stat(s[i]);
			chk("executed", n + (s[i][2] ? 0 : 1), dev.nexec);
			bus_op(1'b1, REG_STATUS, 32'hE);
		end
		chk("range", 32'h3E80, dev.pmem[0][0]);
		$display("limits test done");
	end
	endtask
	task automatic t_params();
		logic [7:0] c [9] = '{8'h06, 8'h07, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h60, 8'h64, 8'h61};
	begin
		for (int i = 0; i < 9; i++)
		begin
			d = (i == 8) ? 32'h0000_1F40 : 32'h8000_0001 + (i << 20);
			issue(c[i], 4'(1 << (i % 4)), d);
			chk("words", i == 8 ? 1 : 2, dev.words);
			chk("param", i == 8 ? {16'h0, d[15:0]} : d, dev.pmem[i % 4][c[i]]);
		end
		issue(8'h0A, 4'hF, 32'hFFFF_FFFE);
		for (int a = 0; a < 4; a++) chk("all axes", 32'hFFFF_FFFE, dev.pmem[a][8'h0A]);
		$display("params test done");
	end
	endtask
	task automatic t_read();
		logic [31:0] e [5] = '{32'hFEDC_BA98, 32'hFFFF_FFFE, 32'h1F40, 32'h1, 32'h8765_4321};
	begin
		issue(8'h09, 4'h4, 32'hFEDC_BA98);
		for (int i = 0; i < 5; i++)
		begin
			issue(CMD_RD_FIRST + 8'(i), 4'h4, 32'h0);
			bus_op(1'b0, REG_RDATA, 32'h0);
			chk("read data", e[i], q);
		end
		n = dev.nexec;
		issue(CMD_AXIS_NOP, 4'h8, 32'h0);
		chk("axis", 32'h3, dev.sel);
		chk("noop", n + 1, dev.nexec);
		$display("read test done");
	end
	endtask
	task automatic t_drive();
		logic [7:0] c [11] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h62, 8'h63, 8'h65};
	begin
		for (int i = 0; i < 11; i++)
		begin
			issue(c[i], 4'h1, 32'h0);
			chk("code", c[i], dev.last_code);
			stat(6'h30);
		end
		n = dev.nexec;
		bus_op(1'b1, REG_CTRL, {20'h0, 4'h1, CMD_DRV_CONT_M});
		bus_op(1'b1, REG_CTRL, {20'h0, 4'h1, CMD_DRV_LAST});
		idle();
		chk("pair", n + 2, dev.nexec);
		chk("code", CMD_DRV_LAST, dev.last_code);
		chk("gap", 0, dev.gap_bad);
		$display("drive test done");
	end
	endtask
////////////////////////////////////////
	initial
	begin
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		t_refuse();
		t_limits();
		t_params();
		t_read();
		t_drive();
		end_sim();
	end
	initial
	begin
		#400000;
		errors++;
		end_sim();
	end
endmodule
`default_nettype wire
